// *** hw/fawt_map.vh ***
`ifndef FAWT_MAP_VH
`define FAWT_MAP_VH

// Register offsets (word addresses of the internal register map).
`define FAWT_ADDR_ACT 8'h10
`define FAWT_ADDR_WDT 8'h11
`define FAWT_ADDR_WIN0 8'h12
`define FAWT_ADDR_WIN1 8'h13
`define FAWT_ADDR_WINT 8'h14
`define FAWT_ADDR_MISC 8'h18

// Reset values.
`define FAWT_RST_ACT 16'h8020
`define FAWT_RST_WDT 6'h18
`define FAWT_RST_WIN 16'hFF00
`define FAWT_RST_MISC 5'h00

// Action codes.
`define FAWT_ACT_NONE 2'h0
`define FAWT_ACT_CLEAR 2'h1
`define FAWT_ACT_ALARM 2'h2
`define FAWT_ACT_HIZ 2'h3

// Action field positions in the action register.
`define FAWT_F_SELF 15:14
`define FAWT_F_DIE 13:12
`define FAWT_F_IN1 11:10
`define FAWT_F_IN0 9:8
`define FAWT_F_LINK 7:6
`define FAWT_F_REF 5:4
`define FAWT_F_OVERR 3:2
`define FAWT_F_OVWARN 1:0

// Watchdog register fields.
`define FAWT_F_UP 5:3
`define FAWT_F_LO 2:1
`define FAWT_B_EN 0

// Misc register fields: polarity bit, pin assign bit, fault count.
`define FAWT_B_POL 0
`define FAWT_B_PIN 1
`define FAWT_F_CNT 4:2

// Window fields.
`define FAWT_F_HI 15:8
`define FAWT_F_LOW 7:0
`define FAWT_LIM_HI_FILL 4'hF
`define FAWT_LIM_LO_FILL 4'h0

// Watchdog tick timing: oscillator rate and divider.
`define FAWT_OSC_HZ 1228800
`define FAWT_TICK_DIV 1024
`define FAWT_CLK_HZ 100000000
`define FAWT_TICK_CYC ((`FAWT_CLK_HZ / (`FAWT_OSC_HZ / `FAWT_TICK_DIV)))

// Watchdog limits in ticks.
`define FAWT_UP0 13'd64
`define FAWT_UP1 13'd128
`define FAWT_UP2 13'd512
`define FAWT_UP3 13'd1024
`define FAWT_UP4 13'd2048
`define FAWT_UP5 13'd3072
`define FAWT_UP6 13'd4096
`define FAWT_UP7 13'd6144
`define FAWT_LO1 13'd64
`define FAWT_LO2 13'd128
`define FAWT_LO3 13'd512

`endif

// *** hw/fawt_regmem.v ***
`timescale 1ns/10ps
`include "fawt_map.vh"

// Three 16-bit window registers with registered read data.
module fawt_regmem (
    input wire clock,
    input wire sys_rst,
    input wire clk_en,
    input wire wr_en,
    input wire [1:0] wr_idx,
    input wire [15:0] wr_data,
    input wire [1:0] rd_idx,
    output reg [15:0] rd_data,
    output wire [47:0] all_words
);
    reg [15:0] mem [0:2];
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_word
            always @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    mem[gi] <= `FAWT_RST_WIN; // RL18
                end else if (clk_en && wr_en && wr_idx == gi) begin
                    mem[gi] <= wr_data;
                end
            end
            assign all_words[gi*16 +: 16] = mem[gi];
        end
    endgenerate

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 16'h0000;
        end else if (clk_en) begin
            rd_data <= (rd_idx == 2'h3) ? 16'h0000 : mem[rd_idx];
        end
    end
endmodule // fawt_regmem

// *** hw/fawt_top.v ***
// Contract
// RL1: Self-diagnostic action field, default alarm voltage.
// RL2: Die temperature window action field, default none.
// RL3: Input one window action field, default none.
// RL4: Input zero window action field, default none.
// RL5: Shared link check or timeout action.
// RL6: Reference fault action, default alarm voltage.
// RL7: Overheat error action, above 130 C.
// RL8: Overheat warning action, above 85 C.
// RL9: Watchdog ticks at 1200 Hz.
// RL10: Enabled watchdog errors past upper limit.
// RL11: Upper limit code maps 64 to 6144.
// RL12: Lower limit code 0 disables window.
// RL13: Windowed mode: only watchdog write restarts, early errors.
// RL14: Unwindowed mode: any write restarts timer.
// RL15: Enable bit zero, reset disabled.
// RL16: High limit appends ones; greater flags fault.
// RL17: Low limit appends zeros; less flags fault.
// RL18: Windows reset wide open.
// RL19: Alarm level from polarity bit or pin.
// RL20: Window fault trips after count plus one.
// RL21: Masked faults take no action.
// RL22: Most severe requested action wins.
// RL23: Enable or limit change restarts counter.
`timescale 1ns/10ps
`include "fawt_map.vh"

module fawt_top (
    input wire clock,
    input wire sys_rst,
    input wire clk_en,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output reg reg_rvalid,
    input wire [11:0] die_heat_result,
    input wire die_heat_valid,
    input wire [11:0] analog_input_zero,
    input wire analog_input_zero_valid,
    input wire [11:0] analog_input_one,
    input wire analog_input_one_valid,
    input wire self_diag_fault,
    input wire link_check_fault,
    input wire reference_fault,
    input wire overheat_error,
    input wire overheat_warning,
    input wire polarity_select_pin,
    input wire [7:0] fault_mask,
    output reg [1:0] dac_action,
    output reg alarm_level_high,
    output reg watchdog_error,
    output reg [2:0] window_fault
);
    localparam TICK_CYC = `FAWT_TICK_CYC;
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    reg [15:0] fault_action_select;
    reg [5:0] watchdog_config;
    reg [4:0] misc_config;
    reg [16:0] tick_div;
    reg tick;
    reg [12:0] wd_count;
    reg wd_state;
    reg [12:0] up_lim;
    reg [12:0] lo_lim;
    reg [2:0] fault_run [0:2];
    reg [1:0] next_action;

    wire [47:0] win_words;
    wire [1:0] self_diag_fault_action = fault_action_select[`FAWT_F_SELF]; // RL1
    wire [1:0] die_heat_fault_action = fault_action_select[`FAWT_F_DIE]; // RL2
    wire [1:0] input_one_fault_action = fault_action_select[`FAWT_F_IN1]; // RL3
    wire [1:0] input_zero_fault_action = fault_action_select[`FAWT_F_IN0]; // RL4
    wire [1:0] link_check_timeout_action = fault_action_select[`FAWT_F_LINK]; // RL5
    wire [1:0] reference_fault_action = fault_action_select[`FAWT_F_REF]; // RL6
    wire [1:0] overheat_error_action = fault_action_select[`FAWT_F_OVERR]; // RL7
    wire [1:0] overheat_warning_action = fault_action_select[`FAWT_F_OVWARN]; // RL8
    wire [2:0] watchdog_upper_limit = watchdog_config[`FAWT_F_UP];
    wire [1:0] watchdog_lower_limit = watchdog_config[`FAWT_F_LO];
    wire watchdog_enable = watchdog_config[`FAWT_B_EN]; // RL15
    wire alarm_level_polarity = misc_config[`FAWT_B_POL];
    wire input_one_pin_assign = misc_config[`FAWT_B_PIN];
    wire [2:0] successive_fault_count = misc_config[`FAWT_F_CNT];

    wire wr_act = reg_wr && reg_addr == `FAWT_ADDR_ACT;
    wire wr_wdt = reg_wr && reg_addr == `FAWT_ADDR_WDT;
    wire wr_misc = reg_wr && reg_addr == `FAWT_ADDR_MISC;
    wire wr_win = reg_wr && (reg_addr == `FAWT_ADDR_WIN0 || reg_addr == `FAWT_ADDR_WIN1
                  || reg_addr == `FAWT_ADDR_WINT);
    // Window registers sit at three consecutive offsets, the first one at index zero.
    wire [1:0] win_idx = reg_addr[1:0] - 2'h2;
    wire [5:0] wdt_new = reg_wdata[5:0];
    wire lo_on = watchdog_lower_limit != 2'h0;
    // A write that changes the watchdog setup restarts the count without judging it.
    wire cfg_change = wr_wdt && (wdt_new != watchdog_config); // RL23
    // With the lower window on, only a watchdog register write counts as a restart.
    wire kick = lo_on ? wr_wdt : reg_wr; // RL13 RL14
    wire late = wd_count > up_lim; // RL10
    wire early = lo_on && wr_wdt && wd_count < lo_lim; // RL13

    fawt_regmem u_mem (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .wr_en(wr_win),
        .wr_idx(win_idx),
        .wr_data(reg_wdata),
        .rd_idx(win_idx),
        .rd_data(),
        .all_words(win_words)
    );

    // Register writes.
    // Reserved bits of the watchdog and misc words are dropped on write.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fault_action_select <= `FAWT_RST_ACT;
            watchdog_config <= `FAWT_RST_WDT;
            misc_config <= `FAWT_RST_MISC;
        end else if (clk_en) begin
            if (wr_act) begin
                fault_action_select <= reg_wdata;
            end
            if (wr_wdt) begin
                watchdog_config <= wdt_new;
            end
            if (wr_misc) begin
                misc_config <= reg_wdata[4:0];
            end
        end
    end

    // Register reads; data and valid both stand in the cycle after the strobe.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
            case (reg_addr)
                `FAWT_ADDR_ACT: begin
                    reg_rdata <= fault_action_select;
                end
                `FAWT_ADDR_WDT: begin
                    reg_rdata <= {10'h000, watchdog_config};
                end
                `FAWT_ADDR_MISC: begin
                    reg_rdata <= {11'h000, misc_config};
                end
                `FAWT_ADDR_WIN0, `FAWT_ADDR_WIN1, `FAWT_ADDR_WINT: begin
                    reg_rdata <= win_words[win_idx*16 +: 16];
                end
                default: begin
                    reg_rdata <= 16'h0000;
                end
            endcase
        end
    end

    // Tick of 1200 Hz derived from the system clock.
    // One tick spans more than 65535 system clocks, so the divider needs 17 bits.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tick_div <= 17'h00000;
            tick <= 1'b0;
        end else if (clk_en) begin
            tick <= 1'b0;
            if (tick_div == TICK_CYC[16:0] - 17'h00001) begin
                tick_div <= 17'h00000;
                tick <= 1'b1; // RL9
            end else begin
                tick_div <= tick_div + 17'h00001;
            end
        end
    end

    always @* begin
        case (watchdog_upper_limit) // RL11
            3'h0: up_lim = `FAWT_UP0;
            3'h1: up_lim = `FAWT_UP1;
            3'h2: up_lim = `FAWT_UP2;
            3'h3: up_lim = `FAWT_UP3;
            3'h4: up_lim = `FAWT_UP4;
            3'h5: up_lim = `FAWT_UP5;
            3'h6: up_lim = `FAWT_UP6;
            default: up_lim = `FAWT_UP7;
        endcase
        case (watchdog_lower_limit) // RL12
            2'h1: lo_lim = `FAWT_LO1;
            2'h2: lo_lim = `FAWT_LO2;
            2'h3: lo_lim = `FAWT_LO3;
            default: lo_lim = 13'd0;
        endcase
    end

    // Watchdog: error is sticky until restarted by a good kick or disable.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wd_state <= ST_IDLE;
            wd_count <= 13'd0;
            watchdog_error <= 1'b0;
        end else if (clk_en) begin
            case (wd_state)
                ST_IDLE: begin
                    wd_count <= 13'd0;
                    watchdog_error <= 1'b0;
                    if (watchdog_enable) begin
                        wd_state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!watchdog_enable) begin
                        wd_state <= ST_IDLE;
                        watchdog_error <= 1'b0;
                    end else if (cfg_change) begin
                        wd_count <= 13'd0; // RL23
                    end else if (kick) begin
                        wd_count <= 13'd0;
                        if (early || late) begin
                            watchdog_error <= 1'b1; // RL13
                        end else begin
                            watchdog_error <= 1'b0;
                        end
                    end else begin
                        // The count stops one past the limit so a late restart is still late.
                        if (tick && !late) begin
                            wd_count <= wd_count + 13'd1;
                        end
                        if (late) begin
                            watchdog_error <= 1'b1; // RL10
                        end
                    end
                end
                default: wd_state <= ST_IDLE;
            endcase
        end
    end

    // Window comparators with successive-fault filters.
    // Channel order matches the window registers: input zero, input one, die.
    wire [35:0] results = {die_heat_result, analog_input_one, analog_input_zero};
    wire [2:0] valids = {die_heat_valid, analog_input_one_valid, analog_input_zero_valid};
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
            wire [15:0] win = win_words[ch*16 +: 16];
            wire [11:0] hi_lim = {win[`FAWT_F_HI], `FAWT_LIM_HI_FILL};
            wire [11:0] lo_lim_c = {win[`FAWT_F_LOW], `FAWT_LIM_LO_FILL};
            wire [11:0] res = results[ch*12 +: 12];
            wire out_win = (res > hi_lim) || (res < lo_lim_c); // RL16 RL17
            always @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    fault_run[ch] <= 3'h0;
                    window_fault[ch] <= 1'b0;
                end else if (clk_en && valids[ch]) begin
                    if (!out_win) begin
                        fault_run[ch] <= 3'h0;
                        window_fault[ch] <= 1'b0;
                    end else if (fault_run[ch] >= successive_fault_count) begin
                        window_fault[ch] <= 1'b1; // RL20
                    end else begin
                        fault_run[ch] <= fault_run[ch] + 3'h1;
                    end
                end
            end
        end
    endgenerate

    // Action arbitration: higher code is more severe.
    wire [7:0] active = {self_diag_fault, window_fault[2], window_fault[1], window_fault[0],
                         link_check_fault | watchdog_error, reference_fault,
                         overheat_error, overheat_warning} & ~fault_mask; // RL21
    wire [15:0] acts = {self_diag_fault_action, die_heat_fault_action, input_one_fault_action,
                        input_zero_fault_action, link_check_timeout_action,
                        reference_fault_action, overheat_error_action,
                        overheat_warning_action};
    // Equal codes from several faults ask for the same response, so ties need no order.
    integer k;
    always @* begin
        next_action = `FAWT_ACT_NONE;
        for (k = 0; k < 8; k = k + 1) begin
            if (active[k] && acts[k*2 +: 2] > next_action) begin
                next_action = acts[k*2 +: 2]; // RL22
            end
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dac_action <= `FAWT_ACT_NONE;
            alarm_level_high <= 1'b0;
        end else if (clk_en) begin
            dac_action <= next_action;
            // The polarity pin counts only while it is not taken as an analog input.
            alarm_level_high <= alarm_level_polarity
                                | (polarity_select_pin & ~input_one_pin_assign); // RL19
        end
    end
endmodule // fawt_top

// *** verif/fawt_chk.sv ***
`timescale 1ns/10ps
module fawt_chk (
    input wire clock,
    input wire sys_rst,
    input wire clk_en,
    input wire reg_wr,
    input wire reg_rd,
    input wire reg_rvalid,
    input wire die_heat_valid,
    input wire analog_input_zero_valid,
    input wire analog_input_one_valid,
    input wire self_diag_fault,
    input wire link_check_fault,
    input wire reference_fault,
    input wire overheat_error,
    input wire overheat_warning,
    input wire [7:0] fault_mask,
    input wire [1:0] dac_action,
    input wire watchdog_error,
    input wire [2:0] window_fault
);
    wire [7:0] act_src;
    // Unmasked fault sources, in the bit order of the mask port.
    assign act_src = {self_diag_fault, window_fault, link_check_fault | watchdog_error,
        reference_fault, overheat_error, overheat_warning} & ~fault_mask;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    sequence rd_req;
        reg_rd && clk_en;
    endsequence
    sequence rd_ans;
        reg_rvalid;
    endsequence
    rd_answer_a: assert property (rd_req |=> rd_ans) else $error("read not answered");
    rd_cause_a: assert property (rd_ans |-> $past(reg_rd) && $past(clk_en))
        else $error("stray rvalid");
    mask_all_a: assert property ($past(fault_mask) == 8'hFF |-> dac_action == 2'h0)
        else $error("action while all masked");
    act_cause_a: assert property (dac_action != 2'h0 |-> |$past(act_src) || (|act_src))
        else $error("action without fault");
    dog_clear_a: assert property (
        $fell(watchdog_error) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("watchdog error cleared without write");
    zero_rise_a: assert property ($rose(window_fault[0]) |-> $past(analog_input_zero_valid))
        else $error("input zero fault without sample");
    one_rise_a: assert property ($rose(window_fault[1]) |-> $past(analog_input_one_valid))
        else $error("input one fault without sample");
    die_rise_a: assert property ($rose(window_fault[2]) |-> $past(die_heat_valid))
        else $error("die fault without sample");
endmodule // fawt_chk

// *** verif/fawt_host_model.sv ***
`timescale 1ns/10ps
module fawt_host_model (
    input wire clock,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end
    // Each write is a one-cycle strobe; it kicks the watchdog only while the lower window is off, else only a watchdog register write does.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
        @(posedge clock);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clock);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule // fawt_host_model

// *** verif/fault_action_watchdog_thresholds_tb_top.sv ***
`timescale 1ns/10ps
module fault_action_watchdog_thresholds_tb_top;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en, reg_wr, reg_rd, reg_rvalid, polarity_select_pin;
    logic alarm_level_high, watchdog_error;
    logic [7:0] reg_addr, fault_mask;
    logic [15:0] reg_wdata, reg_rdata;
    logic [11:0] res [3];
    logic [2:0] vld, window_fault;
    logic [4:0] lvl;
    logic [1:0] dac_action;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    always #5 clock = ~clock;
    fawt_host_model host_u (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    fawt_top dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .die_heat_result(res[2]), .die_heat_valid(vld[2]),
        .analog_input_zero(res[0]), .analog_input_zero_valid(vld[0]),
        .analog_input_one(res[1]), .analog_input_one_valid(vld[1]),
        .self_diag_fault(lvl[4]), .link_check_fault(lvl[3]), .reference_fault(lvl[2]),
        .overheat_error(lvl[1]), .overheat_warning(lvl[0]),
        .polarity_select_pin(polarity_select_pin), .fault_mask(fault_mask),
        .dac_action(dac_action), .alarm_level_high(alarm_level_high),
        .watchdog_error(watchdog_error), .window_fault(window_fault));
    task automatic test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            test_done;
        end
    end
    task automatic chk(input logic c, input string m);
        total_checks++;
        if (c !== 1'b1) begin
            failures++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic ok;
        host_u.rd(a, d, ok);
        chk(ok === 1'b1 && d === e, "register read");
    endtask
    task automatic feed(input int ch, input logic [11:0] v, input logic e);
        res[ch] = v;
        vld[ch] = 1'b1;
        step(1);
        vld[ch] = 1'b0;
        res[ch] = ~v;
        chk(window_fault[ch] === e, "window fault");
        step(1);
    endtask
    task automatic t_regs;
        logic [7:0] a [7] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h18, 8'h20};
        logic [15:0] e [7] = '{16'h8020, 16'h0018, 16'hFF00, 16'hFF00, 16'hFF00, 0, 0};
        logic [15:0] w [7] = '{16'h5A5A, 16'hFFF0, 16'h1234, 16'hABCD, 16'h0F0F, '1, '1};
        logic [15:0] x [7] = '{16'h5A5A, 16'h0030, 16'h1234, 16'hABCD, 16'h0F0F, 16'h001F, 0};
        feed(0, 12'hFFF, 1'b0);
        feed(0, 12'h000, 1'b0);
        for (int i = 0; i < 7; i++)
            rchk(a[i], e[i]);
        for (int i = 0; i < 7; i++) begin
            host_u.wr(a[i], w[i]);
            rchk(a[i], x[i]);
        end
        for (int i = 0; i < 6; i++)
            host_u.wr(a[i], e[i]);
        $display("test regs done");
    endtask
    task automatic t_act;
        int sh [5] = '{0, 2, 4, 6, 14};
        fault_mask = 8'h00;
        for (int f = 0; f < 5; f++) begin
            for (int c = 0; c < 4; c++) begin
                host_u.wr(8'h10, 16'(c) << sh[f]);
                lvl = 5'(1 << f);
                step(2);
                chk(dac_action === 2'(c), "action code");
                lvl = 5'h00;
            end
        end
        host_u.wr(8'h10, 16'h4030);
        lvl = 5'h14;
        step(2);
        chk(dac_action === 2'h3, "severity");
        fault_mask = 8'h04;
        step(2);
        chk(dac_action === 2'h1, "masked fault");
        fault_mask = 8'hFF;
        lvl = 5'h00;
        $display("test actions done");
    endtask
    task automatic t_win(input int ch);
        host_u.wr(8'h12 + 8'(ch), 16'h8010);
        host_u.wr(8'h18, 16'h0004);
        host_u.wr(8'h10, 16'h0200 << (2 * ch));
        fault_mask = ~(8'h10 << ch);
        feed(ch, 12'h80F, 1'b0);
        feed(ch, 12'h810, 1'b0);
        feed(ch, 12'h810, 1'b1);
        chk(dac_action === 2'h2, "window action");
        feed(ch, 12'h100, 1'b0);
        feed(ch, 12'h0FF, 1'b0);
        feed(ch, 12'h0FF, 1'b1);
        fault_mask = 8'hFF;
        host_u.wr(8'h12 + 8'(ch), 16'hFF00);
        $display("test window done");
    endtask
    task automatic t_pol;
        host_u.wr(8'h18, 16'h0001);
        step(1);
        chk(alarm_level_high === 1'b1, "polarity bit");
        host_u.wr(8'h18, 16'h0000);
        polarity_select_pin = 1'b1;
        step(1);
        chk(alarm_level_high === 1'b1, "polarity pin");
        host_u.wr(8'h18, 16'h0002);
        step(1);
        chk(alarm_level_high === 1'b0, "pin assigned");
        polarity_select_pin = 1'b0;
        $display("test polarity done");
    endtask
    task automatic t_dog;
        fault_mask = 8'hF7;
        host_u.wr(8'h10, 16'h00C0);
        host_u.wr(8'h11, 16'h0019);
        host_u.wr(8'h12, 16'hFF00);
        step(2);
        chk(watchdog_error === 1'b0, "open kick");
        host_u.wr(8'h11, 16'h001B);
        step(2);
        chk(watchdog_error === 1'b0, "config restart");
        host_u.wr(8'h12, 16'hFF00);
        step(2);
        chk(watchdog_error === 1'b0, "other write");
        host_u.wr(8'h11, 16'h001B);
        step(2);
        chk(watchdog_error === 1'b1 && dac_action === 2'h3, "early kick");
        host_u.wr(8'h11, 16'h0018);
        step(1);
        chk(watchdog_error === 1'b0, "disable");
        fault_mask = 8'hFF;
        $display("test watchdog done");
    endtask
    initial begin
        clk_en = 1'b1;
        lvl = 5'h00;
        res = '{default: 12'h000};
        vld = 3'h0;
        fault_mask = 8'hFF;
        polarity_select_pin = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        t_regs;
        t_act;
        for (int ch = 0; ch < 3; ch++)
            t_win(ch);
        t_pol;
        t_dog;
        test_done;
    end
endmodule // fault_action_watchdog_thresholds_tb_top
bind fawt_top fawt_chk chk_u (.clock, .sys_rst, .clk_en, .reg_wr, .reg_rd, .reg_rvalid,
    .die_heat_valid, .analog_input_zero_valid, .analog_input_one_valid, .self_diag_fault,
    .link_check_fault, .reference_fault, .overheat_error, .overheat_warning, .fault_mask,
    .dac_action, .watchdog_error, .window_fault);
